/* core/peq_regs.sv */
// equalizer training and cable diagnostic register bank with diagnostic sequencer
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`include "peq_defs.svh"

module peq_regs
   import peq_pkg::*;
(
   input  wire logic          clk_sys,      // 50 MHz system clock
   input  wire logic          rst_n,        // synchronous reset, active low
   input  wire logic [8:0]    reg_addr,     // register offset
   input  wire logic [15:0]   reg_wdata,    // write data
   input  wire logic          reg_wr,       // write strobe
   input  wire logic          reg_rd,       // read strobe
   output logic      [15:0]   reg_rdata,    // read data, cycle after strobe
   output peq_dsp_cfg_s       dsp_cfg,      // equalizer training settings
   output peq_tdr_req_s       tdr_req,      // reflectometry engine request
   input  peq_tdr_rsp_s       tdr_rsp,      // reflectometry engine answer
   output logic               diag_busy     // diagnostic in progress
);

   // register storage
   logic [15:0] feq_ctrl_q;
   logic [15:0] agc_bw_q;
   logic [14:0] recov_thr_q;
   logic [14:0] tloop_thr_q;
   logic [14:0] linkup_thr_q;
   logic [15:0] train_tmr_q;
   logic [15:0] gain_lim_q;
   logic [15:0] retrain_q;
   logic [3:0]  diag_low_q;
   logic [7:0]  diag_sum_q;
   logic        start_q;
   logic [14:0] tdr_ctrl_q;
   logic [15:0] tdr_pulse_q;
   logic [15:0] tdr_listen_q;
   logic [15:0] tdr_short_q;
   logic [15:0] rdata_q;

   // sequencer state
   peq_diag_e   state_q;
   logic        pair_rx_q;
   logic [6:0]  avg_cnt_q;
   logic [6:0]  avg_last;
   logic [2:0]  avg_code;
   logic        tx_byp;
   logic        rx_byp;
   logic        any_pair;
   logic        accept;
   logic        meas_end;
   logic        last_meas;

   // write decode helper
   function automatic logic hit(input logic [8:0] off);
      hit = reg_wr && (reg_addr == off);
   endfunction : hit

   // plain read/write configuration registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         feq_ctrl_q   <= `PEQ_RST_FEQ_CTRL;
         agc_bw_q     <= `PEQ_RST_AGC_BW;
         recov_thr_q  <= `PEQ_RST_RECOV_THR;
         tloop_thr_q  <= `PEQ_RST_TLOOP_THR;
         linkup_thr_q <= `PEQ_RST_LINKUP_THR;
         train_tmr_q  <= `PEQ_RST_TRAIN_TMR;
         gain_lim_q   <= `PEQ_RST_GAIN_LIM;
         retrain_q    <= `PEQ_RST_RETRAIN;
         tdr_ctrl_q   <= `PEQ_RST_TDR_CTRL;
         tdr_pulse_q  <= `PEQ_RST_TDR_PULSE;
         tdr_listen_q <= `PEQ_RST_TDR_LISTEN;
         tdr_short_q  <= `PEQ_RST_TDR_SHORT;
         diag_low_q   <= `PEQ_RST_DIAG_LOW;
      end else begin
         if (hit(`PEQ_OFF_FEQ_CTRL))   feq_ctrl_q   <= reg_wdata;
         if (hit(`PEQ_OFF_AGC_BW))     agc_bw_q     <= reg_wdata;
         if (hit(`PEQ_OFF_RECOV_THR))  recov_thr_q  <= reg_wdata[14:0];
         if (hit(`PEQ_OFF_TLOOP_THR))  tloop_thr_q  <= reg_wdata[14:0];
         if (hit(`PEQ_OFF_LINKUP_THR)) linkup_thr_q <= reg_wdata[14:0];
         if (hit(`PEQ_OFF_TRAIN_TMR))  train_tmr_q  <= reg_wdata;
         if (hit(`PEQ_OFF_GAIN_LIM))   gain_lim_q   <= reg_wdata;
         if (hit(`PEQ_OFF_RETRAIN))    retrain_q    <= reg_wdata;
         // bit 15 is read-only; engine request and sequencer see changes at once, even during a run
         if (hit(`PEQ_OFF_TDR_CTRL))   tdr_ctrl_q   <= reg_wdata[14:0];
         if (hit(`PEQ_OFF_TDR_PULSE))  tdr_pulse_q  <= reg_wdata;
         if (hit(`PEQ_OFF_TDR_LISTEN)) tdr_listen_q <= reg_wdata;
         if (hit(`PEQ_OFF_TDR_SHORT))  tdr_short_q  <= reg_wdata;
         if (hit(`PEQ_OFF_DIAG))       diag_low_q   <= reg_wdata[3:0];
      end
   end

   // equalizer settings straight from the register flops
   always_comb begin
      dsp_cfg.feq_ctrl    = feq_ctrl_q;
      dsp_cfg.agc_bw      = agc_bw_q;
      dsp_cfg.recov_thr   = recov_thr_q;
      dsp_cfg.tloop_thr   = tloop_thr_q;
      dsp_cfg.linkup_thr  = linkup_thr_q;
      dsp_cfg.tmr_state   = train_tmr_q[14:12];
      dsp_cfg.tmr_tloop   = train_tmr_q[11:6];
      dsp_cfg.tmr_gain_a  = train_tmr_q[5:3];
      dsp_cfg.tmr_gain_b  = train_tmr_q[2:0];
      dsp_cfg.gain_max    = gain_lim_q[7:4];
      dsp_cfg.gain_min    = gain_lim_q[3:0];
      dsp_cfg.retrain_dis = retrain_q[`PEQ_BIT_NO_RETRAIN];
   end

   // diagnostic control decode
   assign tx_byp   = tdr_ctrl_q[`PEQ_BIT_TX_BYPASS];
   assign rx_byp   = tdr_ctrl_q[`PEQ_BIT_RX_BYPASS];
   assign any_pair = !tx_byp || !rx_byp;
   // reserved code 7 is run as 64 rather than left undefined
   assign avg_code = (tdr_ctrl_q[`PEQ_AVG_HI:`PEQ_AVG_LO] > `PEQ_AVG_MAX) ?
                     `PEQ_AVG_MAX : tdr_ctrl_q[`PEQ_AVG_HI:`PEQ_AVG_LO];
   assign avg_last = 7'((8'h1 << avg_code) - 8'h1);
   assign accept   = start_q && (state_q == PEQ_IDLE);
   assign meas_end = (state_q == PEQ_WAIT) && tdr_rsp.done;
   assign last_meas = meas_end && (avg_cnt_q == avg_last);

   // start bit: taken only while idle, cleared once the sequencer accepts it
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         start_q <= 1'b0;
      end else if (hit(`PEQ_OFF_DIAG) && reg_wdata[`PEQ_BIT_DIAG_START] &&
                   state_q == PEQ_IDLE && !start_q) begin
         start_q <= 1'b1;
      end else if (accept) begin
         start_q <= 1'b0;
      end
   end

   // measurement sequencer: transmit pair first, then receive pair
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q   <= PEQ_IDLE;
         pair_rx_q <= 1'b0;
         avg_cnt_q <= 7'h00;
      end else begin
         unique case (state_q)
            PEQ_IDLE: begin
               avg_cnt_q <= 7'h00;
               if (accept && any_pair) begin
                  pair_rx_q <= tx_byp;
                  state_q   <= PEQ_ISSUE;
               end
            end
            PEQ_ISSUE: begin
               state_q <= PEQ_WAIT;
            end
            PEQ_WAIT: begin
               if (last_meas) begin
                  avg_cnt_q <= 7'h00;
                  if (!pair_rx_q && !rx_byp) begin
                     pair_rx_q <= 1'b1;
                     state_q   <= PEQ_ISSUE;
                  end else begin
                     state_q <= PEQ_IDLE;
                  end
               end else if (meas_end) begin
                  avg_cnt_q <= avg_cnt_q + 7'h01;
                  state_q   <= PEQ_ISSUE;
               end
            end
         endcase
      end
   end

   // last engine sum is kept for software
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         diag_sum_q <= 8'h00;
      end else if (meas_end) begin
         diag_sum_q <= tdr_rsp.sum;
      end
   end

   // engine request, combinational launch pulse from state
   always_comb begin
      tdr_req.start      = (state_q == PEQ_ISSUE);
      tdr_req.pair_rx    = pair_rx_q;
      tdr_req.cross_en   = !tdr_ctrl_q[`PEQ_BIT_CROSS_DIS];
      tdr_req.pulse_ctrl = tdr_pulse_q[3:0];
      tdr_req.listen_len = tdr_listen_q[15:8];
      tdr_req.short_thr  = tdr_short_q[12:8];
   end

   assign diag_busy = (state_q != PEQ_IDLE);

   // read mux; unmapped offsets read zero
   function automatic logic [15:0] read_word(input logic [8:0] off);
      unique case (off)
         `PEQ_OFF_FEQ_CTRL:   read_word = feq_ctrl_q;
         `PEQ_OFF_AGC_BW:     read_word = agc_bw_q;
         `PEQ_OFF_RECOV_THR:  read_word = {1'b0, recov_thr_q};
         `PEQ_OFF_TLOOP_THR:  read_word = {1'b0, tloop_thr_q};
         `PEQ_OFF_LINKUP_THR: read_word = {1'b0, linkup_thr_q};
         `PEQ_OFF_TRAIN_TMR:  read_word = train_tmr_q;
         `PEQ_OFF_GAIN_LIM:   read_word = gain_lim_q;
         `PEQ_OFF_RETRAIN:    read_word = retrain_q;
         `PEQ_OFF_DIAG:       read_word = {start_q, 2'b00, diag_busy,
                                           diag_sum_q, diag_low_q};
         `PEQ_OFF_TDR_CTRL:   read_word = {1'b0, tdr_ctrl_q};
         `PEQ_OFF_TDR_PULSE:  read_word = tdr_pulse_q;
         `PEQ_OFF_TDR_LISTEN: read_word = tdr_listen_q;
         `PEQ_OFF_TDR_SHORT:  read_word = tdr_short_q;
         default:             read_word = 16'h0000;
      endcase
   endfunction : read_word

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= reg_rd ? read_word(reg_addr) : 16'h0000;
      end
   end

   assign reg_rdata = rdata_q;

   // checks on register and diagnostic behaviour
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_launch_write;
      reg_wr && reg_addr == `PEQ_OFF_DIAG && reg_wdata[`PEQ_BIT_DIAG_START] &&
      state_q == PEQ_IDLE && !start_q && any_pair;
   endsequence

   sequence s_launch_seen;
      start_q ##1 (diag_busy && tdr_req.start);
   endsequence

   a_start_launch: assert property (s_launch_write |=> s_launch_seen)
      else $error("diagnostic start did not launch a measurement");

   a_zero_no_launch: assert property (
      reg_wr && reg_addr == `PEQ_OFF_DIAG && !reg_wdata[15] && !start_q &&
      state_q == PEQ_IDLE |=> ##1 !diag_busy)
      else $error("writing zero to start launched a diagnostic");

   a_start_self_clear: assert property (start_q |=> !start_q)
      else $error("start bit not cleared after acceptance");

   a_status_read: assert property (
      reg_rd && reg_addr == `PEQ_OFF_DIAG |=>
      reg_rdata[`PEQ_BIT_DIAG_BUSY] == $past(diag_busy))
      else $error("status bit disagrees with diagnostic activity");

   a_cross_mode: assert property (
      reg_wr && reg_addr == `PEQ_OFF_TDR_CTRL |=> tdr_req.cross_en == !$past(reg_wdata[14]))
      else $error("cross mode does not follow cross-disable bit");

   a_tx_bypass_skip: assert property (
      tdr_req.start && !tdr_req.pair_rx |-> !tx_byp)
      else $error("transmit pair measured while bypassed");

   a_rx_bypass_skip: assert property (
      tdr_req.start && tdr_req.pair_rx |-> !rx_byp)
      else $error("receive pair measured while bypassed");

   a_avg_continue: assert property (
      meas_end && avg_cnt_q != avg_last |=> tdr_req.start && diag_busy)
      else $error("averaging stopped before its count");

   a_busy_until_end: assert property (
      meas_end && (avg_cnt_q != avg_last || (!pair_rx_q && !rx_byp))
      |=> diag_busy)
      else $error("status cleared with measurements outstanding");

   a_pulse_field: assert property (
      reg_wr && reg_addr == `PEQ_OFF_TDR_PULSE |=>
      tdr_req.pulse_ctrl == $past(reg_wdata[3:0]))
      else $error("pulse control not taken from bits 3:0");

   a_recov_thr: assert property (
      reg_wr && reg_addr == `PEQ_OFF_RECOV_THR |=>
      dsp_cfg.recov_thr == $past(reg_wdata[14:0]))
      else $error("recovery threshold not updated");

   a_retrain_dis: assert property (
      reg_wr && reg_addr == `PEQ_OFF_RETRAIN |=>
      dsp_cfg.retrain_dis == $past(reg_wdata[11]))
      else $error("retrain disable does not follow bit 11");

   // field writes reach the training and reflectometry settings a cycle later
   a_listen_field: assert property (
      reg_wr && reg_addr == `PEQ_OFF_TDR_LISTEN |=>
      tdr_req.listen_len == $past(reg_wdata[15:8]))
      else $error("listen duration not taken from bits 15:8");

   a_tloop_thr: assert property (
      reg_wr && reg_addr == `PEQ_OFF_TLOOP_THR |=>
      dsp_cfg.tloop_thr == $past(reg_wdata[14:0]))
      else $error("timing loop threshold not updated");

   a_linkup_thr: assert property (
      reg_wr && reg_addr == `PEQ_OFF_LINKUP_THR |=>
      dsp_cfg.linkup_thr == $past(reg_wdata[14:0]))
      else $error("link-up threshold not updated");

   a_train_timers: assert property (
      reg_wr && reg_addr == `PEQ_OFF_TRAIN_TMR |=>
      {dsp_cfg.tmr_state, dsp_cfg.tmr_tloop, dsp_cfg.tmr_gain_a, dsp_cfg.tmr_gain_b} ==
      $past(reg_wdata[14:0]))
      else $error("training timers not taken from bits 14:0");

   a_gain_limits: assert property (
      reg_wr && reg_addr == `PEQ_OFF_GAIN_LIM |=>
      {dsp_cfg.gain_max, dsp_cfg.gain_min} == $past(reg_wdata[7:0]))
      else $error("gain index limits not taken from bits 7:0");

   // reserved top bits of the threshold and control words read zero
   a_top_bit_zero: assert property (
      reg_rd && (reg_addr == `PEQ_OFF_RECOV_THR || reg_addr == `PEQ_OFF_TLOOP_THR ||
                 reg_addr == `PEQ_OFF_LINKUP_THR || reg_addr == `PEQ_OFF_TDR_CTRL)
      |=> !reg_rdata[15])
      else $error("reserved top bit read as one");

   // diagnostic run: launch, pair order, averaging and completion
   sequence s_pair_switch;
      meas_end && avg_cnt_q == avg_last && !pair_rx_q && !rx_byp;
   endsequence

   sequence s_rx_issue;
      tdr_req.start && tdr_req.pair_rx && diag_busy;
   endsequence

   a_rx_follows_tx: assert property (s_pair_switch |=> s_rx_issue)
      else $error("receive pair not measured after transmit pair");

   a_busy_launch: assert property (accept && any_pair |=> diag_busy)
      else $error("status not set when the diagnostic started");

   a_bypass_both: assert property (
      accept && !any_pair |=> !diag_busy && !start_q)
      else $error("diagnostic ran with both pairs bypassed");

   a_idle_after_last: assert property (
      last_meas && (pair_rx_q || rx_byp) |=> !diag_busy)
      else $error("status still set after the final measurement");

   a_busy_start_drop: assert property (
      reg_wr && reg_addr == `PEQ_OFF_DIAG && diag_busy |=> !start_q)
      else $error("start accepted while a diagnostic was running");

   a_start_pulse: assert property (tdr_req.start |=> !tdr_req.start)
      else $error("launch pulse longer than one cycle");

   a_avg_bound: assert property (meas_end |-> avg_cnt_q <= avg_last)
      else $error("averaging count ran past its limit");

   a_sum_stored: assert property (
      meas_end |=> diag_sum_q == $past(tdr_rsp.sum))
      else $error("measurement sum not stored");

   // a stray answer outside a measurement must leave the stored sum alone
   a_stray_done: assert property (
      tdr_rsp.done && state_q != PEQ_WAIT |=> $stable(diag_sum_q))
      else $error("engine answer taken while no measurement was running");

endmodule : peq_regs

/* shared/peq_defs.svh */
// register offsets, field positions and reset values of the equalizer / diagnostic bank
`ifndef PEQ_DEFS_SVH
`define PEQ_DEFS_SVH

// register offsets (word addresses on the register port)
`define PEQ_OFF_FEQ_CTRL     9'h114
`define PEQ_OFF_AGC_BW       9'h116
`define PEQ_OFF_RECOV_THR    9'h121
`define PEQ_OFF_TLOOP_THR    9'h122
`define PEQ_OFF_LINKUP_THR   9'h123
`define PEQ_OFF_TRAIN_TMR    9'h126
`define PEQ_OFF_GAIN_LIM     9'h129
`define PEQ_OFF_RETRAIN      9'h130
`define PEQ_OFF_DIAG         9'h155
`define PEQ_OFF_TDR_CTRL     9'h170
`define PEQ_OFF_TDR_PULSE    9'h171
`define PEQ_OFF_TDR_LISTEN   9'h173
`define PEQ_OFF_TDR_SHORT    9'h177

// reset values
`define PEQ_RST_FEQ_CTRL     16'h400a
`define PEQ_RST_AGC_BW       16'h014a
`define PEQ_RST_RECOV_THR    15'h199a
`define PEQ_RST_TLOOP_THR    15'h1027
`define PEQ_RST_LINKUP_THR   15'h051c
`define PEQ_RST_TRAIN_TMR    16'h461b
`define PEQ_RST_GAIN_LIM     16'h000f
`define PEQ_RST_RETRAIN      16'h0001
`define PEQ_RST_DIAG_LOW     4'h1
`define PEQ_RST_TDR_CTRL     15'h0e52
`define PEQ_RST_TDR_PULSE    16'hc85c
`define PEQ_RST_TDR_LISTEN   16'hff1e
`define PEQ_RST_TDR_SHORT    16'h189b

// field positions
`define PEQ_BIT_DIAG_START   15
`define PEQ_BIT_DIAG_BUSY    12
`define PEQ_BIT_CROSS_DIS    14
`define PEQ_BIT_TX_BYPASS    13
`define PEQ_BIT_RX_BYPASS    12
`define PEQ_BIT_NO_RETRAIN   11
`define PEQ_AVG_HI           10
`define PEQ_AVG_LO           8
`define PEQ_AVG_MAX          3'h6

`endif

/* shared/peq_pkg.sv */
// types shared by the equalizer and cable diagnostic register bank
package peq_pkg;

   // diagnostic sequencer states, one-hot
   typedef enum logic [2:0] {
      PEQ_IDLE  = 3'b001,
      PEQ_ISSUE = 3'b010,
      PEQ_WAIT  = 3'b100
   } peq_diag_e;

   // settings handed to the equalizer training logic
   typedef struct packed {
      logic [15:0] feq_ctrl;        // feedback equalizer control word
      logic [15:0] agc_bw;          // gain control bandwidth word
      logic [14:0] recov_thr;       // error limit that forces recovery
      logic [14:0] tloop_thr;       // timing_loop_error_limit
      logic [14:0] linkup_thr;      // linkup_error_limit
      logic [2:0]  tmr_state;       // state shift timer
      logic [5:0]  tmr_tloop;       // timing loop timer
      logic [2:0]  tmr_gain_a;      // first gain loop timer
      logic [2:0]  tmr_gain_b;      // second gain loop timer
      logic [3:0]  gain_max;        // highest allowed gain index
      logic [3:0]  gain_min;        // lowest allowed gain index
      logic        retrain_dis;     // gain retraining forbidden
   } peq_dsp_cfg_s;

   // one measurement request to the reflectometry engine
   typedef struct packed {
      logic        start;           // one-cycle launch pulse
      logic        pair_rx;         // 0 transmit_pair, 1 receive pair
      logic        cross_en;        // watch the other pair as well
      logic [3:0]  pulse_ctrl;      // expected self reflection
      logic [7:0]  listen_len;      // listening duration
      logic [4:0]  short_thr;       // short cable compensation
   } peq_tdr_req_s;

   // engine answer
   typedef struct packed {
      logic        done;            // one-cycle pulse, measurement finished
      logic [7:0]  sum;             // accumulated result of that measurement
   } peq_tdr_rsp_s;

endpackage : peq_pkg

/* dv/tb_top.sv */
// self-checking bench for the equalizer and cable diagnostic register bank
`timescale 1ns/100ps
`include "peq_defs.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); end end

module tb_top
   import peq_pkg::*;
;
   // register table: offsets, reset values and writable masks in the same order
   localparam logic [8:0]  ADDR [13] = '{`PEQ_OFF_FEQ_CTRL, `PEQ_OFF_AGC_BW, `PEQ_OFF_RECOV_THR,
      `PEQ_OFF_TLOOP_THR, `PEQ_OFF_LINKUP_THR, `PEQ_OFF_TRAIN_TMR, `PEQ_OFF_GAIN_LIM,
      `PEQ_OFF_RETRAIN, `PEQ_OFF_DIAG, `PEQ_OFF_TDR_CTRL, `PEQ_OFF_TDR_PULSE,
      `PEQ_OFF_TDR_LISTEN, `PEQ_OFF_TDR_SHORT};
   localparam logic [15:0] RSTV [13] = '{`PEQ_RST_FEQ_CTRL, `PEQ_RST_AGC_BW,
      {1'b0, `PEQ_RST_RECOV_THR}, {1'b0, `PEQ_RST_TLOOP_THR}, {1'b0, `PEQ_RST_LINKUP_THR},
      `PEQ_RST_TRAIN_TMR, `PEQ_RST_GAIN_LIM, `PEQ_RST_RETRAIN, {12'h000, `PEQ_RST_DIAG_LOW},
      {1'b0, `PEQ_RST_TDR_CTRL}, `PEQ_RST_TDR_PULSE, `PEQ_RST_TDR_LISTEN, `PEQ_RST_TDR_SHORT};
   localparam logic [15:0] WM   [13] = '{16'hffff, 16'hffff, 16'h7fff, 16'h7fff, 16'h7fff,
      16'hffff, 16'hffff, 16'hffff, 16'h000f, 16'h7fff, 16'hffff, 16'hffff, 16'hffff};
   // diagnostic cases {averaging code, transmit bypass, receive bypass, cross disable}
   localparam logic [5:0]  CASES [8] = '{6'b000_00_0, 6'b001_10_1, 6'b010_01_0, 6'b011_11_0,
      6'b100_00_1, 6'b101_01_0, 6'b110_10_1, 6'b111_00_0};

   logic           clk_sys;      // system clock
   logic           rst_n;        // reset, active low
   logic [8:0]     reg_addr;     // register offset
   logic [15:0]    reg_wdata;    // write data
   logic           reg_wr;       // write strobe
   logic           reg_rd;       // read strobe
   logic [15:0]    reg_rdata;    // read data
   peq_dsp_cfg_s   dsp_cfg;      // training settings
   peq_tdr_req_s   tdr_req;      // engine request
   peq_tdr_rsp_s   tdr_rsp;      // engine answer, driven here
   logic           diag_busy;    // diagnostic running
   int             n_mismatch = 0;
   int             comparisons = 0;
   logic [31:0]    expq [$];     // {mask, value} per read
   logic           pairs [$];    // pair of every launched measurement
   logic [15:0]    sh [13];      // shadow of register contents
   logic [7:0]     last_sum = 8'h00;
   logic           rd_d = 1'b0;
   logic           stray = 1'b0; // asks the engine stand-in for an unprompted answer

   peq_regs i_dut (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_rdata (reg_rdata),
      .dsp_cfg   (dsp_cfg),
      .tdr_req   (tdr_req),
      .tdr_rsp   (tdr_rsp),
      .diag_busy (diag_busy)
   );

   // 50 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // expected read value: status clear, last sum in bits 11:4
   function automatic logic [15:0] rexp(input int i);
      rexp = (i == 8) ? (sh[8] | {4'h0, last_sum, 4'h0}) : sh[i];
   endfunction : rexp

   task automatic wr(input logic [8:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [8:0] a, input logic [15:0] e, input logic [15:0] m);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      expq.push_back({m, e});
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
   endtask : rd

   // settings leave the bank as plain levels; let the write edge settle first
   task automatic chk_cfg();
      #1;
      `CHK(dsp_cfg.feq_ctrl, sh[0])
      `CHK(dsp_cfg.agc_bw, sh[1])
      `CHK(dsp_cfg.recov_thr, sh[2][14:0])
      `CHK(dsp_cfg.tloop_thr, sh[3][14:0])
      `CHK(dsp_cfg.linkup_thr, sh[4][14:0])
      `CHK({dsp_cfg.tmr_state, dsp_cfg.tmr_tloop, dsp_cfg.tmr_gain_a, dsp_cfg.tmr_gain_b}, sh[5][14:0])
      `CHK({dsp_cfg.gain_max, dsp_cfg.gain_min}, sh[6][7:0])
      `CHK(dsp_cfg.retrain_dis, sh[7][11])
      `CHK(tdr_req.cross_en, ~sh[9][14])
      `CHK(tdr_req.pulse_ctrl, sh[10][3:0])
      `CHK(tdr_req.listen_len, sh[11][15:8])
      `CHK(tdr_req.short_thr, sh[12][12:8])
   endtask : chk_cfg

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude

   // read monitor: data only in the cycle after the strobe, zero otherwise
   always @(posedge clk_sys) begin
      logic [31:0] e;
      if (rd_d) begin
         e = expq.pop_front();
         `CHK(reg_rdata & e[31:16], e[15:0] & e[31:16])
      end else if (rst_n === 1'b1) begin
         `CHK(reg_rdata, 16'h0000)
      end
      rd_d <= reg_rd;
   end

   // engine stand-in: answers each launch after a random delay with a random sum
   initial begin
      tdr_rsp = '0;
      forever begin
         @(posedge clk_sys);
         if (tdr_req.start === 1'b1) begin
            pairs.push_back(tdr_req.pair_rx);
            `CHK(diag_busy, 1'b1)
            repeat ($urandom_range(2)) @(posedge clk_sys);
            last_sum = 8'($urandom);
            tdr_rsp  <= '{done: 1'b1, sum: last_sum};
            @(posedge clk_sys);
            tdr_rsp  <= '0;
         end else if (stray) begin
            // answer with no launch, which the bank must ignore
            tdr_rsp  <= '{done: 1'b1, sum: 8'ha5};
            @(posedge clk_sys);
            tdr_rsp  <= '0;
         end
      end
   end

   // hang guard, far beyond the longest diagnostic run
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      conclude();
   end

   initial begin
      int n, ntx, nrx, k;
      logic [5:0]  c;
      logic [15:0] w;
      void'($urandom(32'hcf84));
      rst_n = 1'b0; reg_addr = 9'h000; reg_wdata = 16'h0000; reg_wr = 1'b0; reg_rd = 1'b0;
      foreach (sh[i]) sh[i] = RSTV[i];
      repeat (5) @(posedge clk_sys);
      #1;
      `CHK(diag_busy, 1'b0)
      @(posedge clk_sys);
      rst_n <= 1'b1;
      // reset values, then an unmapped place that must read zero and ignore writes
      for (int i = 0; i < 13; i++) rd(ADDR[i], RSTV[i], 16'hffff);
      chk_cfg();
      wr(9'h115, 16'hffff);
      rd(9'h115, 16'h0000, 16'hffff);
      rd(9'h1ff, 16'h0000, 16'hffff);
      // random contents, read back at once; reserved top bits must stay zero
      for (int r = 0; r < 3; r++) begin
         for (int i = 0; i < 13; i++) begin
            w = 16'($urandom);
            if (i == 8) w[15] = 1'b0;
            wr(ADDR[i], w);
            sh[i] = w & WM[i];
            rd(ADDR[i], rexp(i), 16'hffff);
         end
         chk_cfg();
      end
      `CHK(diag_busy, 1'b0)
      `CHK(pairs.size(), 0)
      // a stray engine answer while idle changes nothing
      @(posedge clk_sys);
      stray <= 1'b1;
      @(posedge clk_sys);
      stray <= 1'b0;
      @(posedge clk_sys);
      rd(ADDR[8], rexp(8), 16'hffff);
      // one diagnostic per averaging code with varied bypass and cross settings
      for (int i = 0; i < 8; i++) begin
         c   = CASES[i];
         n   = 1 << ((c[5:3] == 3'h7) ? 6 : c[5:3]);
         ntx = c[2] ? 0 : n;
         nrx = c[1] ? 0 : n;
         sh[9] = {1'b0, c[0], c[2], c[1], 1'b1, c[5:3], 8'h52};
         wr(ADDR[9], sh[9]);
         chk_cfg();
         wr(ADDR[8], 16'h8000 | sh[8]);
         @(posedge clk_sys);
         #1;
         `CHK(diag_busy, (ntx + nrx) != 0)
         if (ntx + nrx != 0) rd(ADDR[8], 16'h1000, 16'h9000);
         // a second launch during a run is dropped, not queued
         if (ntx + nrx >= 4) wr(ADDR[8], 16'h8000 | sh[8]);
         k = 0;
         while (diag_busy !== 1'b0 && k < 3000) begin
            @(posedge clk_sys);
            k++;
         end
         `CHK(diag_busy, 1'b0)
         `CHK(pairs.size(), ntx + nrx)
         foreach (pairs[j]) `CHK(pairs[j], j >= ntx)
         `CHK(pairs.size() - ntx, nrx)
         pairs.delete();
         rd(ADDR[8], rexp(8), 16'hffff);
      end
      repeat (3) @(posedge clk_sys);
      conclude();
   end
endmodule : tb_top
